// File: rtl/bgs_scan_driver.sv
// Purpose: Scan sequencer for a 100-segment glow-transfer bar graph tube.
// Assumes: level_i is synchronous and already quantized to 0..100.
// Notes: Cathode lines are active low; a low line pulls that cathode to ground.
//        The level is taken during each reset slot and held for the phase slots.
//        Timing comes from the package constants; nothing is tunable at run time.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Keep-alive segment anode current is on at all times.
// - Each scan starts with anode raised and reset cathode pulled low.
// - Phase lines pulse in order one, two, three, each moving glow one segment.
// - Exactly three phase cathode lines and one reset cathode line are driven.
// - Staircase ramp rises one step per phase pulse, top step 99 in the last phase slot.
// - Anode stays high until ramp exceeds the held input level, then drops for the scan.
// - Full-scale input lights all 100 segments.
// - After 100 phase pulses a reset pulse starts a new scan.
// - Complete scans repeat at 70 Hz.
module bgs_scan_driver (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [6:0] level_i,
  output bgs_pkg::bgs_tube_s tube_o,
  output logic [6:0] ramp_o,
  output logic scan_start_o
);
  import bgs_pkg::*;

  // Slot timer. One scan is a reset slot plus 100 phase slots; the slot length is
  // rounded down, so the scan rate lands a hair above 70 Hz rather than below it.
  logic [SLOT_W-1:0] slot_reg;
  logic [SLOT_W-1:0] slot_next;
  logic slot_end;

  // Scan sequencer: reset slot, then phase slots 0..99 with a rotating phase
  bgs_state_e state_reg;
  bgs_state_e state_next;
  logic [6:0] seg_reg;
  logic [6:0] seg_next;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic step_last;

  // Anode gate and the level frozen for the scan
  logic anode_reg;
  logic anode_next;
  logic [6:0] level_reg;
  logic [6:0] level_next;
  logic ramp_above;
  logic scan_entry;

  // Tube drive is registered so that no decode glitch can reach a cathode line
  bgs_tube_s tube_reg;
  bgs_tube_s tube_next;
  logic pulse_next;
  logic [2:0] phase_sel;

  // Next cathode phase in the fixed one, two, three rotation
  function automatic logic [1:0] phase_after(input logic [1:0] phase);
    phase_after = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
  endfunction : phase_after

  // Quantized level held to the height of the bar
  function automatic logic [6:0] level_clamp(input logic [6:0] level);
    level_clamp = (level > LEVEL_FULL) ? LEVEL_FULL : level;
  endfunction : level_clamp

  // First half of a slot carries the pulse, the second half lets the glow settle
  function automatic logic pulse_window(input logic [SLOT_W-1:0] slot);
    pulse_window = (slot < PULSE_LEN);
  endfunction : pulse_window

  // The slot counter wraps on every slot, whatever the sequencer state
  always_comb begin
    slot_next = slot_end ? SLOT_RST : slot_reg + 12'h001;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      slot_reg <= SLOT_RST;
    end else begin
      slot_reg <= slot_next;
    end
  end

  assign slot_end = (slot_reg == SLOT_LAST);
  // Last phase slot of the scan: the step taken now would be the hundredth
  assign step_last = (seg_reg + 7'h01 == SEG_LAST);

  // The sequencer moves only on slot boundaries. A scan always runs all 100
  // phase slots, even for a short bar, so the scan rate does not depend on the
  // level; the anode alone decides how far the glow climbs.
  always_comb begin
    state_next = state_reg;
    seg_next = seg_reg;
    phase_next = phase_reg;
    case (state_reg)
      BGS_RESET_SLOT: begin
        if (slot_end) begin
          state_next = BGS_PHASE_SLOT;
          seg_next = SEG_RST;
          phase_next = PHASE_RST;
        end
      end

      BGS_PHASE_SLOT: begin
        if (slot_end) begin
          seg_next = seg_reg + 7'h01;
          phase_next = phase_after(phase_reg);
          if (step_last) begin
            state_next = BGS_RESET_SLOT;
          end
        end
      end

      default: begin
        state_next = BGS_RESET_SLOT;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= BGS_RESET_SLOT;
      seg_reg <= SEG_RST;
      phase_reg <= PHASE_RST;
    end else begin
      state_reg <= state_next;
      seg_reg <= seg_next;
      phase_reg <= phase_next;
    end
  end

  // The drop is judged on the count after the step, so the anode is already
  // low when the next cathode pulse arrives and that segment never ignites.
  assign ramp_above = (seg_reg + 7'h01 > level_reg);
  // A new scan begins on the edge that leaves the last phase slot
  assign scan_entry = (state_reg != BGS_RESET_SLOT) && (state_next == BGS_RESET_SLOT);

  // Anode rises with every new scan and falls at most once within it. The
  // reset value is high, so the scan that follows a reset behaves like any other.
  always_comb begin
    anode_next = anode_reg;
    level_next = level_reg;
    // Ramp now above the level: stop glow transfer for this scan
    if (state_reg == BGS_PHASE_SLOT && slot_end && ramp_above) begin
      anode_next = 1'b0;
    end
    if (scan_entry) begin
      anode_next = 1'b1;
    end
    // Level follows the input through the reset slot and is frozen for the phase
    // slots, so the bar cannot tear mid-scan; the first scan after reset uses it.
    // A level change inside the phase slots shows only on the next scan.
    if (state_reg == BGS_RESET_SLOT) begin
      level_next = level_clamp(level_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      anode_reg <= 1'b1;
      level_reg <= SEG_RST;
    end else begin
      anode_reg <= anode_next;
      level_reg <= level_next;
    end
  end

  assign pulse_next = (state_next == BGS_PHASE_SLOT) && pulse_window(slot_next);

  // One select per phase line; the phase value lets at most one be active
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign phase_sel[g] = pulse_next && (phase_next == 2'(g));
    end
  endgenerate

  // Cathode lines are active low and idle high. The reset cathode stays low for
  // the whole reset slot; the keep-alive supply never goes dark.
  always_comb begin
    tube_next.keep_alive = 1'b1;
    tube_next.anode_high = anode_next;
    tube_next.reset_cathode_n = (state_next != BGS_RESET_SLOT);
    tube_next.phase_cathode_n = ~phase_sel;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tube_reg.anode_high <= 1'b1;
      tube_reg.keep_alive <= 1'b1;
      tube_reg.reset_cathode_n <= 1'b0;
      tube_reg.phase_cathode_n <= 3'h7;
    end else begin
      tube_reg.anode_high <= tube_next.anode_high;
      tube_reg.keep_alive <= tube_next.keep_alive;
      tube_reg.reset_cathode_n <= tube_next.reset_cathode_n;
      tube_reg.phase_cathode_n <= tube_next.phase_cathode_n;
    end
  end

  assign tube_o = tube_reg;
  // Ramp reads zero in the reset slot and k in phase slot k; it changes in the same
  // cycle as the tube lines, which are registered copies of the next state.
  assign ramp_o = (state_reg == BGS_PHASE_SLOT) ? seg_reg : SEG_RST;
  // One-cycle marker on the first cycle of every reset slot, and held in reset
  assign scan_start_o = (state_reg == BGS_RESET_SLOT) && (slot_reg == SLOT_RST);

endmodule : bgs_scan_driver
`default_nettype wire

// File: rtl/bgs_pkg.sv
// Purpose: Shared constants and types for the bar graph scan driver.
// Assumes: 20 MHz system clock, one scan of 100 phase pulses at 70 Hz.
// Notes: Level input is a 7-bit quantized value, 100 meaning full scale.
package bgs_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SCAN_HZ = 70;
  localparam int unsigned SEGMENTS = 100;
  // One reset slot plus one slot per phase pulse in each scan
  localparam int unsigned SLOTS = SEGMENTS + 1;
  localparam int unsigned SLOT_CYCLES = CLK_HZ / (SCAN_HZ * SLOTS);
  // Phase cathode pulse is the first half of each phase slot
  localparam int unsigned PULSE_CYCLES = SLOT_CYCLES / 2;
  localparam int unsigned SLOT_W = 12;
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);
  localparam logic [SLOT_W-1:0] PULSE_LEN = SLOT_W'(PULSE_CYCLES);
  localparam logic [SLOT_W-1:0] SLOT_RST = 12'h000;
  localparam logic [6:0] SEG_LAST = 7'(SEGMENTS);
  localparam logic [6:0] SEG_RST = 7'h00;
  localparam logic [6:0] LEVEL_FULL = 7'(SEGMENTS);
  localparam logic [1:0] PHASE_RST = 2'h0;

  typedef enum logic [1:0] {
    BGS_RESET_SLOT = 2'b00,
    BGS_PHASE_SLOT = 2'b01
  } bgs_state_e;

  typedef struct packed {
    logic anode_high;
    logic keep_alive;
    logic reset_cathode_n;
    logic [2:0] phase_cathode_n;
  } bgs_tube_s;

endpackage : bgs_pkg

// File: testbench/bgs_scan_driver_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bgs_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire bgs_pkg::bgs_tube_s tube_o,
  input wire logic [6:0] ramp_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_ka; tube_o.keep_alive; endproperty
  a_ka: assert property (p_ka) else $error("keep-alive dark");
  property p_ex; $countones(~tube_o[3:0]) < 2; endproperty
  a_ex: assert property (p_ex) else $error("two cathodes low");
  property p_fi; $rose(tube_o.reset_cathode_n) |-> !tube_o.phase_cathode_n[0]; endproperty
  a_fi: assert property (p_fi) else $error("scan not on phase one");
  property p_rp; $changed(ramp_o) && ramp_o != 7'h00 |-> ramp_o == $past(ramp_o) + 7'h01; endproperty
  a_rp: assert property (p_rp) else $error("ramp skipped");
  property p_dn; $fell(tube_o.anode_high) |-> $changed(ramp_o); endproperty
  a_dn: assert property (p_dn) else $error("anode fell off step");
  property p_ra; !tube_o.reset_cathode_n |-> tube_o.anode_high; endproperty
  a_ra: assert property (p_ra) else $error("reset slot without anode");
endmodule : bgs_chk
bind bgs_scan_driver bgs_chk u_chk (.clock_i, .rst_i, .tube_o, .ramp_o);
`default_nettype wire

// File: testbench/bgs_tube.sv
`timescale 1ns/1ps
`default_nettype none
module bgs_tube (
  input wire logic clock_i,
  input wire bgs_pkg::bgs_tube_s tube_i,
  output logic [6:0] height_o
);
  logic [2:0] p_reg;
  always @(posedge clock_i) p_reg <= tube_i.phase_cathode_n;
  always @(posedge clock_i) height_o <= !tube_i.reset_cathode_n ? 7'h00 :
    height_o + 7'(tube_i.anode_high && |(p_reg & ~tube_i.phase_cathode_n));
endmodule : bgs_tube
`default_nettype wire

// File: testbench/tb_bgs_scan_driver.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bgs_scan_driver;
  logic clock_i = 1'b0, rst_i = 1'b1;
  logic [6:0] level_i = 7'h00, ramp_o, height;
  logic scan_start_o;
  bgs_pkg::bgs_tube_s tube_o;
  int errors = 0, n_tests = 0, cyc = 0;
  always #25 clock_i = ~clock_i;
  bgs_scan_driver uut (.clock_i, .rst_i, .level_i, .tube_o, .ramp_o, .scan_start_o);
  bgs_tube tube (.clock_i, .tube_i(tube_o), .height_o(height));
  task chk(input string n, input logic [6:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task report_and_stop;
    if (errors == 0 && n_tests > 0 && cyc < 95000) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  always @(posedge clock_i) if (++cyc >= 95000) begin
    errors++;
    report_and_stop();
  end
  // Reset over four edges with the level applied, then release and run to mid-pulse of phase slot 0
  task start_scan(input logic [6:0] lvl);
    rst_i <= 1'b1;
    level_i <= lvl;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    chk("tube", 7'(tube_o), 7'h37);
    chk("start", 7'(scan_start_o), 7'h01);
    @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (bgs_pkg::SLOT_CYCLES + bgs_pkg::PULSE_CYCLES / 2) @(posedge clock_i);
  endtask : start_scan
  // Settled mid-pulse view of phase slot k
  task chk_slot(input int k, input logic anode, input logic [6:0] hgt);
    @(negedge clock_i);
    chk("phase", 7'(tube_o.phase_cathode_n), 7'h07 ^ (7'h01 << (k % 3)));
    chk("ramp", ramp_o, 7'(k));
    chk("anode", 7'(tube_o.anode_high), 7'(anode));
    chk("height", height, hgt);
    chk("reset", 7'(tube_o.reset_cathode_n), 7'h01);
    chk("alive", 7'(tube_o.keep_alive), 7'h01);
    chk("start", 7'(scan_start_o), 7'h00);
  endtask : chk_slot
  // Zero level: only phase slot zero keeps the anode up
  task t_scan;
    start_scan(7'h00);
    for (int k = 0; k < 12; k++) begin
      chk_slot(k, k == 0, 7'h01);
      repeat (bgs_pkg::SLOT_CYCLES) @(posedge clock_i);
    end
  endtask : t_scan
  // Mid-run reset with an over-range level: clamped to full scale, each of the first 12 pulses climbs
  task t_full;
    start_scan(7'h7F);
    for (int k = 0; k < 12; k++) begin
      chk_slot(k, 1'b1, 7'(k + 1));
      repeat (bgs_pkg::SLOT_CYCLES) @(posedge clock_i);
    end
  endtask : t_full
  initial begin
    t_scan();
    t_full();
    report_and_stop();
  end
endmodule : tb_bgs_scan_driver
`default_nettype wire
